// ===== hdl/fmd_params.svh
`ifndef FMD_PARAMS_SVH
`define FMD_PARAMS_SVH

// ==========================================================
// Clock and timing
// ==========================================================
`define FMD_MCLK_NS          4
`define FMD_SLEEP_ENTRY_NS   3000
`define FMD_WAKE_REC_NS      3000
`define FMD_WAKE_ID_REC_NS   3000
`define FMD_WHOLE_ERASE_NS   1000000
// Least times round up to whole mclk cycles
`define FMD_CYC(ns) ((((ns) + `FMD_MCLK_NS - 1) / `FMD_MCLK_NS))

// ==========================================================
// Frame layout, in serial clocks
// ==========================================================
`define FMD_OPCODE_CLKS      8'h08
`define FMD_HDR_UID_NARROW   8'h28
`define FMD_HDR_UID_WIDE     8'h30
`define FMD_HDR_ID           8'h20
`define FMD_HDR_ID_DUAL      8'h14
`define FMD_HDR_NONE         8'hff
`define FMD_SR_ADS_BIT       8

// ==========================================================
// Host divider, mclk cycles per serial clock half period
// ==========================================================
`define FMD_SCLK_HALF        5

`endif

// ===== hdl/fmd_pkg.sv
package fmd_pkg;

  typedef enum logic [7:0] {
    OP_WHOLE_ERASE_A        = 8'h60,
    OP_WHOLE_ERASE_B        = 8'hc7,
    OP_DEEP_SLEEP_CMD       = 8'hb9,
    OP_UNIQUE_ID            = 8'h4b,
    OP_WIDE_ADDRESS_ENTER   = 8'hb7,
    OP_WIDE_ADDRESS_EXIT    = 8'he9,
    OP_CLEAR_FLAGS          = 8'h30,
    OP_WAKE_AND_IDENTIFIER  = 8'hab,
    OP_MAKER_PART           = 8'h90,
    OP_MAKER_PART_DUAL      = 8'h92
  } fmd_op_t;

  typedef enum logic [2:0] {
    DS_STANDBY     = 3'b000,
    DS_ERASE       = 3'b001,
    DS_SLEEP_ENTRY = 3'b010,
    DS_SLEEP       = 3'b011,
    DS_WAKE        = 3'b100
  } fmd_dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE     = 2'b00,
    HS_SHIFT    = 2'b01,
    HS_DESELECT = 2'b10,
    HS_HOLD     = 2'b11
  } fmd_host_state_t;

endpackage

// ===== hdl/fmd_link_if.sv
`timescale 1ns/1ps
interface fmd_link_if;
  logic cs_n;
  logic sclk;
  logic host_io0_o;
  logic host_io0_oe;
  logic host_io1_o;
  logic host_io1_oe;
  logic dev_io0_o;
  logic dev_io0_oe;
  logic dev_io1_o;
  logic dev_io1_oe;
  logic io0;
  logic io1;

  // ==========================================================
  // Wire resolution, undriven lines float high
  // ==========================================================
  assign io0 = host_io0_oe ? host_io0_o : (dev_io0_oe ? dev_io0_o : 1'b1);
  assign io1 = host_io1_oe ? host_io1_o : (dev_io1_oe ? dev_io1_o : 1'b1);

  modport host (
    output cs_n,
    output sclk,
    output host_io0_o,
    output host_io0_oe,
    output host_io1_o,
    output host_io1_oe,
    input  io0,
    input  io1
  );

  modport dev (
    input  cs_n,
    input  sclk,
    input  io0,
    input  io1,
    output dev_io0_o,
    output dev_io0_oe,
    output dev_io1_o,
    output dev_io1_oe
  );
endinterface

// ===== hdl/fmd_dev_end.sv
`timescale 1ns/1ps
`include "fmd_params.svh"

module fmd_dev_end
  import fmd_pkg::*;
#(
  parameter logic [127:0] UNIQUE_ID    = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978,
  parameter logic [7:0]   DEVICE_ID    = 8'h5a,  // Arbitrary value
  parameter logic [7:0]   MAKER_ID     = 8'ha5,  // Arbitrary value
  parameter logic [7:0]   PART_ID      = 8'h3c,  // Arbitrary value
  parameter int           ERASE_CYC    = `FMD_CYC(`FMD_WHOLE_ERASE_NS),
  parameter int           ENTRY_CYC    = `FMD_CYC(`FMD_SLEEP_ENTRY_NS),
  parameter int           REC_CYC      = `FMD_CYC(`FMD_WAKE_REC_NS),
  parameter int           REC_ID_CYC   = `FMD_CYC(`FMD_WAKE_ID_REC_NS)
) (
  input  wire logic  mclk_i,
  input  wire logic  rst_b_i,
  input  wire logic  ce_i,
  fmd_link_if.dev    link,
  input  wire logic  write_enable_latch_i,
  input  wire logic  ext_busy_i,
  input  wire logic  protect_any_i,
  input  wire logic  soft_reset_i,
  output logic       address_span_flag_o,
  output logic       busy_flag_o,
  output logic       sleep_o,
  output logic       wel_clear_o,
  output logic       flags_clear_o,
  output logic       erase_done_o
);

  // ==========================================================
  // Decode helpers
  // ==========================================================
  function automatic logic [7:0] hdr_len(input logic [7:0] op,
                                         input logic       wide);
    if (op == OP_UNIQUE_ID) begin
      hdr_len = wide ? `FMD_HDR_UID_WIDE : `FMD_HDR_UID_NARROW;
    end else if (op == OP_WAKE_AND_IDENTIFIER || op == OP_MAKER_PART) begin
      hdr_len = `FMD_HDR_ID;
    end else if (op == OP_MAKER_PART_DUAL) begin
      hdr_len = `FMD_HDR_ID_DUAL;
    end else begin
      hdr_len = `FMD_HDR_NONE;
    end
  endfunction

  function automatic logic rd_ok(input logic [7:0] op,
                                 input logic       asleep,
                                 input logic       busy);
    if (op == OP_WAKE_AND_IDENTIFIER) begin
      rd_ok = ~busy;
    end else if (op == OP_UNIQUE_ID || op == OP_MAKER_PART ||
                 op == OP_MAKER_PART_DUAL) begin
      rd_ok = ~asleep;
    end else begin
      rd_ok = 1'b0;
    end
  endfunction

  // ==========================================================
  // Link domain: command capture on the serial clock
  // ==========================================================
  logic         frame_rst_b;
  logic         fresh_r;
  logic [7:0]   cnt_r;
  logic [7:0]   op_r;
  logic [2:0]   wide_ls_r;
  logic [2:0]   sleep_ls_r;
  logic [2:0]   busy_ls_r;
  logic         wide_q_r;
  logic         sleep_q_r;
  logic         busy_q_r;
  logic [6:0]   idx_r;
  logic         io0_r;
  logic         io0_oe_r;
  logic         io1_r;
  logic         io1_oe_r;
  logic [15:0]  maker_part;
  logic         out_act;
  logic         wide_r;
  logic         sleep_src_r;
  logic         busy_src_r;

  assign frame_rst_b = rst_b_i & ~link.cs_n;
  assign maker_part  = {MAKER_ID, PART_ID};

  always_ff @(posedge link.sclk or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  // Count and opcode survive deselect so mclk can judge the frame
  // rising edge capture
  always_ff @(posedge link.sclk or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 8'h00;
      op_r  <= 8'h00;
    end else if (fresh_r) begin
      cnt_r <= 8'h01;
      op_r  <= {7'h00, link.io0};
    end else begin
      if (cnt_r != 8'hff) begin
        cnt_r <= cnt_r + 8'h01;
      end
      if (cnt_r < `FMD_OPCODE_CLKS) begin
        op_r <= {op_r[6:0], link.io0};
      end
    end
  end

  // Serial clock stops between frames, so flags settle early in frame
  always_ff @(posedge link.sclk or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wide_ls_r  <= 3'h0;
      sleep_ls_r <= 3'h0;
      busy_ls_r  <= 3'h0;
      wide_q_r   <= 1'b0;
      sleep_q_r  <= 1'b0;
      busy_q_r   <= 1'b0;
    end else begin
      wide_ls_r  <= {wide_ls_r[1:0], wide_r};
      sleep_ls_r <= {sleep_ls_r[1:0], sleep_src_r};
      busy_ls_r  <= {busy_ls_r[1:0], busy_src_r};
      // A change counts once stages 2 and 3 agree
      if (wide_ls_r[1] == wide_ls_r[2]) begin
        wide_q_r <= wide_ls_r[2];
      end
      if (sleep_ls_r[1] == sleep_ls_r[2]) begin
        sleep_q_r <= sleep_ls_r[2];
      end
      if (busy_ls_r[1] == busy_ls_r[2]) begin
        busy_q_r <= busy_ls_r[2];
      end
    end
  end

  assign out_act = rd_ok(op_r, sleep_q_r, busy_q_r) &&
                   (cnt_r >= hdr_len(op_r, wide_q_r));

  always_ff @(negedge link.sclk or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      idx_r    <= 7'h00;
      io0_r    <= 1'b0;
      io0_oe_r <= 1'b0;
      io1_r    <= 1'b0;
      io1_oe_r <= 1'b0;
    end else if (out_act) begin
      idx_r    <= idx_r + 7'h01;
      io1_oe_r <= 1'b1;
      case (op_r)
        OP_WAKE_AND_IDENTIFIER: begin
          io1_r <= DEVICE_ID[~idx_r[2:0]];
        end
        OP_UNIQUE_ID: begin
          io1_r <= UNIQUE_ID[~idx_r[6:0]];
        end
        OP_MAKER_PART: begin
          io1_r <= maker_part[~idx_r[3:0]];
        end
        OP_MAKER_PART_DUAL: begin
          io1_r    <= maker_part[{~idx_r[2:0], 1'b1}];
          io0_r    <= maker_part[{~idx_r[2:0], 1'b0}];
          io0_oe_r <= 1'b1;
        end
        default: begin
          io1_r <= 1'b0;
        end
      endcase
    end
  end

  assign link.dev_io0_o  = io0_r;
  assign link.dev_io0_oe = io0_oe_r;
  assign link.dev_io1_o  = io1_r;
  assign link.dev_io1_oe = io1_oe_r;

  // ==========================================================
  // Main clock domain: deselect detection and execution
  // ==========================================================
  logic [2:0]      cs_s_r;
  logic            cs_hi_r;
  logic            cs_rise;
  logic            cmd8;
  logic            awake;
  logic            busy_now;
  logic            go_erase;
  logic            go_sleep;
  logic            go_clear;
  fmd_dev_state_t  state_r;
  fmd_dev_state_t  state_nxt;
  logic [31:0]     tmr_r;
  logic [31:0]     tmr_nxt;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_s_r  <= 3'h7;
      cs_hi_r <= 1'b1;
    end else if (ce_i) begin
      cs_s_r <= {cs_s_r[1:0], link.cs_n};
      if (cs_s_r[1] == cs_s_r[2]) begin
        cs_hi_r <= cs_s_r[2];
      end
    end
  end

  // Count and opcode are quasi-static once the select line is high
  assign cs_rise  = cs_s_r[1] & cs_s_r[2] & ~cs_hi_r;
  assign cmd8     = cs_rise & (cnt_r == `FMD_OPCODE_CLKS);
  assign awake    = (state_r == DS_STANDBY) || (state_r == DS_ERASE);
  assign busy_now = (state_r == DS_ERASE) | ext_busy_i;
  assign go_erase = cmd8 & (state_r == DS_STANDBY) & ~ext_busy_i &
                    ((op_r == OP_WHOLE_ERASE_A) ||
                     (op_r == OP_WHOLE_ERASE_B)) &
                    write_enable_latch_i & ~protect_any_i;
  assign go_sleep = cmd8 & (state_r == DS_STANDBY) & ~ext_busy_i &
                    (op_r == OP_DEEP_SLEEP_CMD);
  assign go_clear = cmd8 & awake & ~busy_now & (op_r == OP_CLEAR_FLAGS);

  always_comb begin
    state_nxt = state_r;
    tmr_nxt   = (tmr_r != 32'h0) ? tmr_r - 32'h1 : 32'h0;
    case (state_r)
      DS_STANDBY: begin
        if (go_erase) begin
          state_nxt = DS_ERASE;
          tmr_nxt   = 32'(ERASE_CYC - 1);
        end else if (go_sleep) begin
          state_nxt = DS_SLEEP_ENTRY;
          tmr_nxt   = 32'(ENTRY_CYC - 1);
        end
      end
      DS_ERASE: begin
        if (tmr_r == 32'h0) begin
          state_nxt = DS_STANDBY;
        end
      end
      DS_SLEEP_ENTRY: begin
        if (tmr_r == 32'h0) begin
          state_nxt = DS_SLEEP;
        end
      end
      DS_SLEEP: begin
        if (soft_reset_i) begin
          state_nxt = DS_STANDBY;
        end else if (cs_rise && op_r == OP_WAKE_AND_IDENTIFIER) begin
          if (cnt_r == `FMD_OPCODE_CLKS) begin
            state_nxt = DS_WAKE;
            tmr_nxt   = 32'(REC_CYC - 1);
          end else if (cnt_r >= `FMD_HDR_ID) begin
            state_nxt = DS_WAKE;
            tmr_nxt   = 32'(REC_ID_CYC - 1);
          end
        end
      end
      DS_WAKE: begin
        if (tmr_r == 32'h0) begin
          state_nxt = DS_STANDBY;
        end
      end
      default: begin
        state_nxt = DS_STANDBY;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= DS_STANDBY;
      tmr_r   <= 32'h0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wide_r <= 1'b0;
    end else if (ce_i && cmd8 && awake) begin
      if (op_r == OP_WIDE_ADDRESS_ENTER) begin
        wide_r <= 1'b1;
      end else if (op_r == OP_WIDE_ADDRESS_EXIT) begin
        wide_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_flag_o   <= 1'b0;
      sleep_o       <= 1'b0;
      wel_clear_o   <= 1'b0;
      flags_clear_o <= 1'b0;
      erase_done_o  <= 1'b0;
      sleep_src_r   <= 1'b0;
      busy_src_r    <= 1'b0;
    end else if (ce_i) begin
      busy_flag_o   <= (state_nxt == DS_ERASE);
      sleep_o       <= (state_nxt == DS_SLEEP);
      wel_clear_o   <= go_erase;
      flags_clear_o <= go_clear;
      erase_done_o  <= (state_r == DS_ERASE) && (tmr_r == 32'h0);
      sleep_src_r   <= (state_nxt == DS_SLEEP);
      busy_src_r    <= (state_nxt == DS_ERASE) | ext_busy_i;
    end
  end

  assign address_span_flag_o = wide_r;

endmodule

// ===== hdl/fmd_host_end.sv
`timescale 1ns/1ps
`include "fmd_params.svh"

module fmd_host_end
  import fmd_pkg::*;
#(
  parameter int HALF = `FMD_SCLK_HALF
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_b_i,
  input  wire logic          ce_i,
  fmd_link_if.host           link,
  input  wire logic          cmd_valid_i,
  output logic               cmd_ready_o,
  input  wire logic [7:0]    cmd_op_i,
  input  wire logic [7:0]    cmd_hdr_i,
  input  wire logic [7:0]    cmd_rx_i,
  input  wire logic          cmd_dual_i,
  input  wire logic [15:0]   cmd_hold_i,
  output logic [127:0]       rx_data_o,
  output logic               rx_valid_o
);

  fmd_host_state_t  state_r;
  logic [7:0]       div_r;
  logic             tick;
  logic             sclk_r;
  logic             cs_n_r;
  logic             io0_r;
  logic             io0_oe_r;
  logic             io1_oe_r;
  logic [7:0]       tx_r;
  logic [8:0]       clk_r;
  logic [8:0]       total_r;
  logic [8:0]       rxstart_r;
  logic             dual_r;
  logic [15:0]      hold_r;
  logic [2:0]       s0_r;
  logic [2:0]       s1_r;
  logic             in0_r;
  logic             in1_r;

  assign tick = (div_r == 8'(HALF - 1));

  // ==========================================================
  // Input synchronisers, a change counts once stages 2 and 3 agree
  // ==========================================================
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s0_r  <= 3'h7;
      s1_r  <= 3'h7;
      in0_r <= 1'b1;
      in1_r <= 1'b1;
    end else if (ce_i) begin
      s0_r <= {s0_r[1:0], link.io0};
      s1_r <= {s1_r[1:0], link.io1};
      if (s0_r[1] == s0_r[2]) begin
        in0_r <= s0_r[2];
      end
      if (s1_r[1] == s1_r[2]) begin
        in1_r <= s1_r[2];
      end
    end
  end

  // ==========================================================
  // Frame sequencer; serial clock divided from mclk
  // ==========================================================
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r     <= HS_IDLE;
      cmd_ready_o <= 1'b0;
      div_r       <= 8'h00;
      sclk_r      <= 1'b0;
      cs_n_r      <= 1'b1;
      io0_r       <= 1'b0;
      io0_oe_r    <= 1'b0;
      io1_oe_r    <= 1'b0;
      tx_r        <= 8'h00;
      clk_r       <= 9'h000;
      total_r     <= 9'h000;
      rxstart_r   <= 9'h000;
      dual_r      <= 1'b0;
      hold_r      <= 16'h0000;
    end else if (ce_i) begin
      div_r <= (tick || state_r == HS_IDLE) ? 8'h00 : div_r + 8'h01;
      case (state_r)
        HS_IDLE: begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o <= 1'b0;
            tx_r        <= cmd_op_i;
            io0_r       <= cmd_op_i[7];
            io0_oe_r    <= 1'b1;
            cs_n_r      <= 1'b0;
            clk_r       <= 9'h000;
            dual_r      <= cmd_dual_i;
            rxstart_r   <= 9'(`FMD_OPCODE_CLKS) + {1'b0, cmd_hdr_i};
            total_r     <= 9'(`FMD_OPCODE_CLKS) + {1'b0, cmd_hdr_i} +
                           {1'b0, cmd_rx_i};
            hold_r      <= cmd_hold_i;
            state_r     <= HS_SHIFT;
          end
        end
        HS_SHIFT: begin
          if (tick && !sclk_r) begin
            sclk_r <= 1'b1;
            clk_r  <= clk_r + 9'h001;
          end else if (tick) begin
            sclk_r <= 1'b0;
            if (clk_r == total_r) begin
              state_r <= HS_DESELECT;
            end else begin
              tx_r     <= {tx_r[6:0], 1'b0};
              io0_r    <= tx_r[6];
              // release both lines for dual return
              io0_oe_r <= ~(dual_r && clk_r >= rxstart_r);
              io1_oe_r <= dual_r && clk_r >= 9'(`FMD_OPCODE_CLKS) &&
                          clk_r < rxstart_r;
            end
          end
        end
        HS_DESELECT: begin
          if (tick) begin
            cs_n_r   <= 1'b1;
            io0_oe_r <= 1'b0;
            io1_oe_r <= 1'b0;
            state_r  <= HS_HOLD;
          end
        end
        // stay deselected for the hold count taken from cmd_hold_i
        HS_HOLD: begin
          if (hold_r == 16'h0000) begin
            state_r <= HS_IDLE;
          end else begin
            hold_r <= hold_r - 16'h0001;
          end
        end
        default: begin
          state_r <= HS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Receive path, sampled just before each rising edge
  // ==========================================================
  // read returned bits
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_data_o  <= 128'h0;
      rx_valid_o <= 1'b0;
    end else if (ce_i) begin
      rx_valid_o <= (state_r == HS_DESELECT) && tick;
      if (state_r == HS_SHIFT && tick && !sclk_r && clk_r >= rxstart_r) begin
        rx_data_o <= dual_r ? {rx_data_o[125:0], in1_r, in0_r}
                            : {rx_data_o[126:0], in1_r};
      end
    end
  end

  assign link.cs_n        = cs_n_r;
  assign link.sclk        = sclk_r;
  assign link.host_io0_o  = io0_r;
  assign link.host_io0_oe = io0_oe_r;
  assign link.host_io1_o  = 1'b0;
  assign link.host_io1_oe = io1_oe_r;

endmodule

// ===== verification/fmd_link_sva.sv
`timescale 1ns/1ps
module fmd_link_sva (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_io0_oe,
  input wire logic host_io1_oe,
  input wire logic dev_io0_o,
  input wire logic dev_io0_oe,
  input wire logic dev_io1_o,
  input wire logic dev_io1_oe
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // ==========================================================
  // Link framing
  // ==========================================================
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  AST_CS_SETUP: assert property ($fell(cs_n) |-> !sclk [*5])
    else $error("serial clock early after select");
  AST_SCLK_HALF: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk)
    else $error("serial clock high time wrong");
  // Short deselect would hide the frame end from the mclk side
  AST_CS_HOLD: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("deselect too short");

  // ==========================================================
  // Device drive
  // ==========================================================
  AST_DEV_OE_DESEL: assert property (
    cs_n && $past(cs_n) |-> !dev_io0_oe && !dev_io1_oe)
    else $error("device drives while deselected");
  AST_NO_CONTEND: assert property (
    !(host_io0_oe && dev_io0_oe) && !(host_io1_oe && dev_io1_oe))
    else $error("both ends drive one line");
  AST_DUAL_PAIR: assert property (dev_io0_oe |-> dev_io1_oe)
    else $error("low line driven without high line");
  AST_DEV_STABLE: assert property (
    !cs_n && !$past(cs_n) && sclk && $past(sclk) && dev_io1_oe
    |-> $stable(dev_io1_o) && $stable(dev_io0_o))
    else $error("device data moved while clock high");
endmodule

// ===== verification/flash_misc_command_decoder_tb.sv
`timescale 1ns/1ps
module flash_misc_command_decoder_tb;
  import fmd_pkg::*;
  localparam logic [127:0] UID = 128'h0f0f_1234_5678_9abc_def0_1357_2468_a5c3;
  localparam logic [7:0]   DID = 8'h6d;  // Arbitrary value
  localparam logic [7:0]   MID = 8'hc2;  // Arbitrary value
  localparam logic [7:0]   PID = 8'h17;  // Arbitrary value
  localparam int           ERASE = 1000;
  logic         mclk_i = 1'b0;
  logic         rst_b_i = 1'b0;
  logic         vld = 1'b0;
  logic         write_enable_latch = 1'b0;
  logic         xbusy = 1'b0;
  logic         prot = 1'b0;
  logic         srst = 1'b0;
  logic         dual = 1'b0;
  logic [7:0]   op = 8'h00;
  logic [7:0]   hdr = 8'h00;
  logic [7:0]   rxn = 8'h00;
  logic [15:0]  hold = 16'h000a;
  logic [15:0]  seed = 16'h0029;
  logic         rdy, rxv, span, busy, sleep, wclr, fclr, edone;
  logic [127:0] rxd;
  logic [127:0] exp_q[$];
  logic [127:0] msk_q[$];
  int           error_cnt = 0;
  int           num_checks = 0;
  int           nw = 0, nf = 0, nd = 0, nb = 0;

  always #2 mclk_i = ~mclk_i;

  fmd_link_if lk ();
  fmd_host_end i_fmd_host_end (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .ce_i(1'b1), .link(lk), .cmd_valid_i(vld), .cmd_ready_o(rdy),
    .cmd_op_i(op), .cmd_hdr_i(hdr), .cmd_rx_i(rxn), .cmd_dual_i(dual),
    .cmd_hold_i(hold), .rx_data_o(rxd), .rx_valid_o(rxv));
  fmd_dev_end #(.UNIQUE_ID(UID), .DEVICE_ID(DID), .MAKER_ID(MID),
    .PART_ID(PID), .ERASE_CYC(ERASE), .ENTRY_CYC(5), .REC_CYC(5),
    .REC_ID_CYC(8)) i_fmd_dev_end (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .ce_i(1'b1), .link(lk), .write_enable_latch_i(write_enable_latch),
    .ext_busy_i(xbusy), .protect_any_i(prot), .soft_reset_i(srst),
    .address_span_flag_o(span), .busy_flag_o(busy), .sleep_o(sleep),
    .wel_clear_o(wclr), .flags_clear_o(fclr), .erase_done_o(edone));
  fmd_link_sva i_fmd_link_sva (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .cs_n(lk.cs_n), .sclk(lk.sclk), .host_io0_oe(lk.host_io0_oe),
    .host_io1_oe(lk.host_io1_oe), .dev_io0_o(lk.dev_io0_o),
    .dev_io0_oe(lk.dev_io0_oe), .dev_io1_o(lk.dev_io1_o),
    .dev_io1_oe(lk.dev_io1_oe));

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [127:0] got, input logic [127:0] e);
    num_checks++;
    if (got !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, e);
    end
  endtask

  // Looked at mid-cycle, then back on the rising edge for the next drive
  task automatic flags(input logic [2:0] e);
    @(negedge mclk_i);
    chk({125'h0, span, busy, sleep}, {125'h0, e});
    @(posedge mclk_i);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Frame: opcode, header clocks, readback clocks; expected noted first
  task automatic cmd(input logic [7:0] o, input logic [7:0] h,
                     input logic [7:0] n, input logic d,
                     input logic [127:0] e);
    int w;
    int k;
    w = n * (d ? 2 : 1);
    if (n != 8'h00) begin
      exp_q.push_back(e);
      msk_q.push_back(w >= 128 ? '1 : (128'h1 << w) - 128'h1);
    end
    seed = lfsr(seed);
    op <= o;
    hdr <= h;
    rxn <= n;
    dual <= d;
    // Hold stays above every recovery time so no command lands early
    hold <= {12'h000, seed[3:0]} + 16'h000a;
    vld <= 1'b1;
    k = 0;
    do begin @(posedge mclk_i); k++; end while (rdy !== 1'b1 && k < 500);
    vld <= 1'b0;
    if (rdy !== 1'b1) begin
      k = 5000;
    end else begin
      do begin @(posedge mclk_i); k++; end while (rdy !== 1'b1 && k < 5000);
    end
    if (k >= 5000) begin
      error_cnt++;
      $display("[ERR] %0t wait for ready timed out", $time);
      conclude();
    end
    repeat (12) @(posedge mclk_i);
  endtask

  // Sampled off the active edge to stay clear of flop updates
  always @(negedge mclk_i) begin
    if (wclr === 1'b1) nw++;
    if (fclr === 1'b1) nf++;
    if (edone === 1'b1) nd++;
    if (busy === 1'b1) nb++;
    if (rxv === 1'b1 && exp_q.size() > 0)
      chk(rxd & msk_q.pop_front(), exp_q.pop_front());
  end

  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    logic [7:0] eo;
    int         k;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    flags(3'b000);
    cmd(OP_MAKER_PART, 8'h18, 8'h10, 1'b0, {MID, PID});
    cmd(OP_MAKER_PART_DUAL, 8'h0c, 8'h08, 1'b1, {MID, PID});
    cmd(OP_WAKE_AND_IDENTIFIER, 8'h18, 8'h10, 1'b0, {DID, DID});
    cmd(OP_UNIQUE_ID, 8'h20, 8'h80, 1'b0, UID);
    for (int i = 0; i < 2; i++) begin
      eo = i ? OP_WHOLE_ERASE_B : OP_WHOLE_ERASE_A;
      cmd(eo, 8'h00, 8'h00, 1'b0, 128'h0);
      write_enable_latch <= 1'b1;
      prot <= 1'b1;
      cmd(eo, 8'h00, 8'h00, 1'b0, 128'h0);
      prot <= 1'b0;
      cmd(eo, 8'h08, 8'h00, 1'b0, 128'h0);
      chk(nw, i);
      cmd(eo, 8'h00, 8'h00, 1'b0, 128'h0);
      write_enable_latch <= 1'b0;
      flags(3'b010);
      cmd(OP_CLEAR_FLAGS, 8'h00, 8'h00, 1'b0, 128'h0);
      cmd(OP_WAKE_AND_IDENTIFIER, 8'h18, 8'h08, 1'b0, 128'hff);
      chk(nf, 0);
      k = 0;
      while (nd < i + 1 && k < 3000) begin @(posedge mclk_i); k++; end
      if (k >= 3000) begin
        error_cnt++;
        $display("[ERR] %0t erase never ended", $time);
        conclude();
      end
      chk(nw, i + 1);
      chk(nb, ERASE * (i + 1));
      flags(3'b000);
    end
    xbusy <= 1'b1;
    cmd(OP_DEEP_SLEEP_CMD, 8'h00, 8'h00, 1'b0, 128'h0);
    cmd(OP_CLEAR_FLAGS, 8'h00, 8'h00, 1'b0, 128'h0);
    chk(nf, 0);
    flags(3'b000);
    xbusy <= 1'b0;
    cmd(OP_CLEAR_FLAGS, 8'h00, 8'h00, 1'b0, 128'h0);
    chk(nf, 1);
    cmd(OP_WIDE_ADDRESS_ENTER, 8'h00, 8'h00, 1'b0, 128'h0);
    flags(3'b100);
    cmd(OP_UNIQUE_ID, 8'h28, 8'h80, 1'b0, UID);
    cmd(OP_MAKER_PART, 8'h18, 8'h10, 1'b0, {MID, PID});
    cmd(OP_WIDE_ADDRESS_EXIT, 8'h00, 8'h00, 1'b0, 128'h0);
    flags(3'b000);
    cmd(OP_DEEP_SLEEP_CMD, 8'h00, 8'h00, 1'b0, 128'h0);
    flags(3'b001);
    cmd(OP_WIDE_ADDRESS_ENTER, 8'h00, 8'h00, 1'b0, 128'h0);
    cmd(OP_MAKER_PART, 8'h18, 8'h10, 1'b0, 128'hffff);
    flags(3'b001);
    cmd(OP_WAKE_AND_IDENTIFIER, 8'h00, 8'h00, 1'b0, 128'h0);
    flags(3'b000);
    cmd(OP_DEEP_SLEEP_CMD, 8'h00, 8'h00, 1'b0, 128'h0);
    cmd(OP_WAKE_AND_IDENTIFIER, 8'h18, 8'h08, 1'b0, DID);
    flags(3'b000);
    cmd(OP_WIDE_ADDRESS_ENTER, 8'h00, 8'h00, 1'b0, 128'h0);
    cmd(OP_DEEP_SLEEP_CMD, 8'h00, 8'h00, 1'b0, 128'h0);
    srst <= 1'b1;
    @(posedge mclk_i);
    srst <= 1'b0;
    repeat (12) @(posedge mclk_i);
    flags(3'b100);
    cmd(OP_DEEP_SLEEP_CMD, 8'h00, 8'h00, 1'b0, 128'h0);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    flags(3'b000);
    chk(exp_q.size(), 0);
    conclude();
  end
endmodule
